// >>> core/irpbm_pkg.sv
/*
 Package for the pulse-burst modulator: register indices, control bit positions,
 reset values and timing constants. Assumes a single oscillator clock domain.
*/
package irpbm_pkg;
    localparam logic [2:0] ADDR_HIGH_TIME = 3'h0;
    localparam logic [2:0] ADDR_LOW_TIME = 3'h1;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
    localparam logic [2:0] ADDR_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h4;
    localparam int BIT_WDT_RELOAD = 4;
    localparam int BIT_INT_CLEAR = 3;
    localparam int BIT_PWM = 2;
    localparam int BIT_LONG = 1;
    localparam int BIT_CARRIER = 0;
    localparam logic [7:0] CONTROL_RW_MASK = 8'h07;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [9:0] RESET_COUNT = 10'h000;
    // Pulse length is value plus this many oscillator periods
    localparam logic [9:0] TIME_OFFSET = 10'h002;
    localparam logic [1:0] CARRIER_HALF = 2'h2;

    typedef struct packed {
        logic write;
        logic read;
        logic [2:0] addr;
        logic [7:0] wdata;
    } irpbm_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ON = 4'b0010,
        ST_OFF = 4'b0100,
        ST_LONG = 4'b1000
    } irpbm_state_t;
endpackage : irpbm_pkg

// >>> core/irpbm_modulator.sv
/*
 Pulse-burst modulator for an infrared transmitter, with its derivative register port.
 Assumes the core presents one-cycle write/read strobes on the oscillator clock.
*/
// Notes on behaviour
// - On-time register at 00H; output active for value plus two periods.
// - Off-time register at 01H; output inactive for value plus two periods.
// - Writing 1 to control bit 4 pulses watchdog clear; nothing stored.
// - Writing 1 to control bit 3 clears the burst-done interrupt.
// - Control bit 2 set with bit 1 clear gives an endless on/off train, count ignored.
// - Control bit 1 set gives one pulse of on-time times count.
// - Long pulse with carrier set is chopped at quarter oscillator rate.
// - Control bit 0 set chops each active part at quarter rate.
// - After reset the output pin sits high, its inactive level.
// - Pulses are counted and the burst ends after the programmed number.
// - Loading the counter starts a burst: on, decrement, off, repeat.
// - Count reaching zero sets the interrupt; reloading the count clears it.
// - Control register sits at address 03H.
`timescale 1ns/1ns
module irpbm_modulator #(
    parameter int TIME_W = 8,
    parameter int COUNT_W = 10
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire irpbm_pkg::irpbm_req_t req_i,
    output logic [7:0] rdata_o,
    output logic pulse_out_n_o,
    output logic burst_irq_o,
    output logic watchdog_reload_strobe_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [TIME_W-1:0] pulse_high_time;
    logic [TIME_W-1:0] pulse_low_time;
    logic [2:0] modulator_control;
    logic [COUNT_W-1:0] pulse_count;
    logic [COUNT_W-1:0] timer;
    logic [1:0] carrier_phase;
    logic load_count;
    logic burst_done;
    logic active;
    irpbm_pkg::irpbm_state_t state;

    wire logic wr_ctl = req_i.write && req_i.addr == irpbm_pkg::ADDR_CONTROL;
    wire logic pwm_mode = modulator_control[irpbm_pkg::BIT_PWM];
    wire logic long_pulse_enable = modulator_control[irpbm_pkg::BIT_LONG];
    wire logic carrier_enable = modulator_control[irpbm_pkg::BIT_CARRIER];
    wire logic timer_end = timer == '0;
    wire logic [COUNT_W-1:0] high_load = COUNT_W'(pulse_high_time) + irpbm_pkg::TIME_OFFSET - 10'h001;
    wire logic [COUNT_W-1:0] low_load = COUNT_W'(pulse_low_time) + irpbm_pkg::TIME_OFFSET - 10'h001;

    ////////////////////////////////////////////////////////////////////////////
    // on-time store
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pulse_high_time <= '0;
        end else if (req_i.write && req_i.addr == irpbm_pkg::ADDR_HIGH_TIME) begin
            pulse_high_time <= req_i.wdata[TIME_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pulse_low_time <= '0;
        end else if (req_i.write && req_i.addr == irpbm_pkg::ADDR_LOW_TIME) begin
            pulse_low_time <= req_i.wdata[TIME_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            modulator_control <= '0;
        end else if (wr_ctl) begin
            modulator_control <= req_i.wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            watchdog_reload_strobe_o <= 1'b0;
        end else begin
            watchdog_reload_strobe_o <= wr_ctl && req_i.wdata[irpbm_pkg::BIT_WDT_RELOAD];
        end
    end

    // count loading, high byte write starts burst too
    assign load_count = req_i.write && (req_i.addr == irpbm_pkg::ADDR_COUNT_LOW ||
                        req_i.addr == irpbm_pkg::ADDR_COUNT_HIGH);

    ////////////////////////////////////////////////////////////////////////////
    // burst sequencer
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= irpbm_pkg::ST_IDLE;
            timer <= irpbm_pkg::RESET_COUNT;
            pulse_count <= irpbm_pkg::RESET_COUNT;
            burst_done <= 1'b0;
        end else begin
            burst_done <= 1'b0;
            if (load_count) begin
                if (req_i.addr == irpbm_pkg::ADDR_COUNT_LOW) begin
                    pulse_count <= {pulse_count[COUNT_W-1:8], req_i.wdata};
                end else begin
                    pulse_count <= {req_i.wdata[COUNT_W-9:0], pulse_count[7:0]};
                end
                timer <= high_load;
                state <= long_pulse_enable ? irpbm_pkg::ST_LONG : irpbm_pkg::ST_ON;
            end else begin
                case (state)
                    irpbm_pkg::ST_IDLE: begin
                        timer <= timer;
                    end
                    irpbm_pkg::ST_ON: begin
                        if (!timer_end) begin
                            timer <= timer - 10'h001;
                        end else if (pwm_mode) begin
                            timer <= low_load;
                            state <= irpbm_pkg::ST_OFF;
                        end else if (pulse_count <= 10'h001) begin
                            pulse_count <= '0;
                            burst_done <= 1'b1;
                            state <= irpbm_pkg::ST_IDLE;
                        end else begin
                            pulse_count <= pulse_count - 10'h001;
                            timer <= low_load;
                            state <= irpbm_pkg::ST_OFF;
                        end
                    end
                    irpbm_pkg::ST_OFF: begin
                        if (!timer_end) begin
                            timer <= timer - 10'h001;
                        end else begin
                            timer <= high_load;
                            state <= irpbm_pkg::ST_ON;
                        end
                    end
                    irpbm_pkg::ST_LONG: begin
                        if (!timer_end) begin
                            timer <= timer - 10'h001;
                        end else if (pulse_count <= 10'h001) begin
                            pulse_count <= '0;
                            burst_done <= 1'b1;
                            state <= irpbm_pkg::ST_IDLE;
                        end else begin
                            // Next on-time segment, no gap
                            pulse_count <= pulse_count - 10'h001;
                            timer <= high_load;
                        end
                    end
                    default: begin
                        state <= irpbm_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign active = state == irpbm_pkg::ST_ON || state == irpbm_pkg::ST_LONG;

    // carrier phase restarts at each active start
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            carrier_phase <= '0;
        end else if (!active || load_count) begin
            carrier_phase <= '0;
        end else if (state == irpbm_pkg::ST_ON && timer_end) begin
            carrier_phase <= '0;
        end else begin
            carrier_phase <= carrier_phase + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pulse_out_n_o <= 1'b1;
        end else if (load_count) begin
            pulse_out_n_o <= 1'b0;
        end else if (state == irpbm_pkg::ST_OFF && timer_end) begin
            pulse_out_n_o <= 1'b0;
        end else if (active && !(timer_end && (state == irpbm_pkg::ST_ON ? 1'b1 : pulse_count <= 10'h001))) begin
            pulse_out_n_o <= carrier_enable && (carrier_phase + 2'h1) >= irpbm_pkg::CARRIER_HALF;
        end else begin
            pulse_out_n_o <= 1'b1;
        end
    end

    // interrupt flag; set wins over clear
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            burst_irq_o <= 1'b0;
        end else if (burst_done) begin
            burst_irq_o <= 1'b1;
        end else if (load_count || (wr_ctl && req_i.wdata[irpbm_pkg::BIT_INT_CLEAR])) begin
            burst_irq_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= irpbm_pkg::RESET_BYTE;
        end else if (req_i.read) begin
            case (req_i.addr)
                irpbm_pkg::ADDR_HIGH_TIME: rdata_o <= 8'(pulse_high_time);
                irpbm_pkg::ADDR_LOW_TIME: rdata_o <= 8'(pulse_low_time);
                irpbm_pkg::ADDR_COUNT_LOW: rdata_o <= pulse_count[7:0];
                irpbm_pkg::ADDR_CONTROL: rdata_o <= {5'h00, modulator_control};
                irpbm_pkg::ADDR_COUNT_HIGH: rdata_o <= {6'h00, pulse_count[9:8]};
                default: rdata_o <= irpbm_pkg::RESET_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_reset_output: assert property (@(posedge ref_clk_i) reset_i |=> pulse_out_n_o)
        else $error("output not inactive after reset");
    a_start_active: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        load_count |=> !pulse_out_n_o)
        else $error("burst did not start active");
    a_wdt_strobe: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_ctl && req_i.wdata[irpbm_pkg::BIT_WDT_RELOAD]) |=> watchdog_reload_strobe_o ##1 !watchdog_reload_strobe_o)
        else $error("watchdog strobe not one cycle");
    a_irq_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        burst_done |=> burst_irq_o)
        else $error("interrupt not set at burst end");
    a_irq_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_ctl && req_i.wdata[irpbm_pkg::BIT_INT_CLEAR] && !burst_done) |=> !burst_irq_o)
        else $error("interrupt clear ignored");
    a_ctl_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (req_i.read && req_i.addr == irpbm_pkg::ADDR_CONTROL) |=> rdata_o[7:3] == 5'h00)
        else $error("control upper bits not zero");
    a_pwm_no_done: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (pwm_mode && !long_pulse_enable) |-> !burst_done)
        else $error("pwm burst ended");
    a_on_length_min: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (load_count && !carrier_enable && !long_pulse_enable && !req_i.read)
        |=> !pulse_out_n_o [*2])
        else $error("on-time shorter than two periods");
    a_long_no_gap: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state == irpbm_pkg::ST_LONG && !carrier_enable && !timer_end && !load_count) |=> !pulse_out_n_o)
        else $error("long pulse gapped");
endmodule : irpbm_modulator

// >>> verification/irpbm_core_model.sv
/*
 Core model: issues derivative register writes and reads, one strobe per access.
 Assumes the modulator samples req on the rising edge of the oscillator clock.
*/
`timescale 1ns/1ns
module irpbm_core_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    output irpbm_pkg::irpbm_req_t req_o
);
    initial begin
        req_o = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One strobe per access
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        req_o = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk_i);
        // Idle bus shows inverted values so stale data never looks valid
        req_o = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        req_o = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk_i);
        d = rdata_i;
        req_o = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hff};
    endtask : rd
    // Burst spacing left to the caller
    task automatic burst(input logic [9:0] c);
        wr(irpbm_pkg::ADDR_COUNT_HIGH, {6'h00, c[9:8]});
        wr(irpbm_pkg::ADDR_COUNT_LOW, c[7:0]);
    endtask : burst
endmodule : irpbm_core_model

// >>> verification/test_irpbm_modulator.sv
/*
 Self-checking bench for the pulse-burst modulator.
 Assumes the core model drives all register traffic; no random stimulus.
*/
`timescale 1ns/1ns
module test_irpbm_modulator;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } irpbm_row_t;
    logic ref_clk_i = 1'b0;
    logic reset_i;
    irpbm_pkg::irpbm_req_t req;
    logic [7:0] rdata;
    logic out_n;
    logic irq;
    logic wd_strobe;
    logic [7:0] rv;
    int failures = 0;
    int n_checks = 0;
    int n;
    irpbm_row_t rows [5] = '{'{3'h0, 8'h5a, 8'h5a}, '{3'h1, 8'ha5, 8'ha5}, '{3'h3, 8'hff, 8'h07},
        '{3'h3, 8'h05, 8'h05}, '{3'h6, 8'h33, 8'h00}};
    always #10 ref_clk_i = ~ref_clk_i;
    irpbm_modulator uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata),
        .pulse_out_n_o(out_n), .burst_irq_o(irq), .watchdog_reload_strobe_o(wd_strobe));
    irpbm_core_model core (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // Bounded wait for the first active cycle of a burst
    task automatic go();
        for (int i = 0; i < 4 && out_n !== 1'b0; i++) begin
            @(negedge ref_clk_i);
        end
    endtask : go
    // Length of the current run of one output level
    task automatic span(input logic lvl, input int len);
        int k;
        k = 0;
        while (out_n === lvl && k < 600) begin
            k++;
            @(negedge ref_clk_i);
        end
        check(16'(k), 16'(len));
    endtask : span
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        reset_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check({15'h0, out_n}, 16'h0001);
        check({15'h0, irq}, 16'h0000);
        reset_i = 1'b0;
        foreach (rows[i]) begin
            core.wr(rows[i].a, rows[i].d);
            core.rd(rows[i].a, rv);
            check({8'h00, rv}, {8'h00, rows[i].e});
        end
        core.wr(3'h3, 8'h00);
        core.wr(3'h0, 8'h01);
        core.wr(3'h1, 8'h02);
        core.burst(10'h003);
        go();
        for (int i = 0; i < 3; i++) begin
            span(1'b0, 3);
            if (i < 2) span(1'b1, 4);
        end
        @(negedge ref_clk_i);
        check({15'h0, irq}, 16'h0001);
        repeat (8) @(negedge ref_clk_i);
        check({15'h0, out_n}, 16'h0001);
        core.burst(10'h001);
        check({15'h0, irq}, 16'h0000);
        go();
        span(1'b0, 3);
        @(negedge ref_clk_i);
        check({15'h0, irq}, 16'h0001);
        core.wr(3'h3, 8'h08);
        check({15'h0, irq}, 16'h0000);
        n = 0;
        fork
            core.wr(3'h3, 8'h10);
            repeat (4) begin
                @(negedge ref_clk_i);
                n += int'(wd_strobe === 1'b1);
            end
        join
        check(16'(n), 16'h0001);
        core.wr(3'h3, 8'h02);
        core.burst(10'h002);
        go();
        span(1'b0, 6);
        core.wr(3'h3, 8'h03);
        core.burst(10'h002);
        go();
        span(1'b0, 2);
        span(1'b1, 2);
        span(1'b0, 2);
        core.wr(3'h3, 8'h01);
        core.wr(3'h0, 8'h04);
        core.wr(3'h1, 8'h00);
        core.burst(10'h002);
        go();
        for (int i = 0; i < 7; i++) begin
            span(i[0], 2);
        end
        core.wr(3'h3, 8'h04);
        core.wr(3'h0, 8'h00);
        core.burst(10'h001);
        go();
        repeat (4) begin
            span(1'b0, 2);
            span(1'b1, 2);
        end
        check({15'h0, irq}, 16'h0000);
        reset_i = 1'b1;
        @(negedge ref_clk_i);
        check({15'h0, out_n}, 16'h0001);
        reset_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check({15'h0, out_n}, 16'h0001);
        check({15'h0, irq}, 16'h0000);
        core.rd(irpbm_pkg::ADDR_CONTROL, rv);
        check({8'h00, rv}, 16'h0000);
        wrap_up();
    end
endmodule : test_irpbm_modulator
